// >>> common/flow_decode_pkg.sv
// Package: constants, field layout and types for the instruction decoder
package flow_decode_pkg;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] INSTR_OFS  = 8'h04;
	localparam logic [7:0] PC_OFS     = 8'h08;
	localparam logic [7:0] SRCA_OFS   = 8'h0c;
	localparam logic [7:0] SRCB_OFS   = 8'h10;
	localparam logic [7:0] WAIT_OFS   = 8'h14;
	localparam logic [7:0] STATUS_OFS = 8'h18;
	localparam logic [7:0] EA_OFS     = 8'h1c;
	localparam logic [7:0] TGT_OFS    = 8'h20;
	localparam logic [7:0] FIELD_OFS  = 8'h24;
	localparam logic [7:0] IMM_OFS    = 8'h28;
	localparam logic [7:0] CFG7_OFS   = 8'h2c;

	// Control bit positions and reset value
	localparam int          CTRL_BIG_BIT   = 0;
	localparam int          CTRL_COMP_BIT  = 1;
	localparam int          CTRL_IE_BIT    = 2;
	localparam int          CTRL_EXEMPT_BIT = 3;
	localparam logic [3:0]  CTRL_RESET     = 4'h1;

	// Status bit positions
	localparam int ST_FMT_LSB   = 0;
	localparam int ST_ADDR_ERR  = 2;
	localparam int ST_FETCH_ERR = 3;
	localparam int ST_RESV      = 4;
	localparam int ST_TRAP      = 5;
	localparam int ST_SLOT      = 6;
	localparam int ST_NULLIFY   = 7;
	localparam int ST_TAKEN     = 8;
	localparam int ST_STALL     = 9;
	localparam int ST_WAITING   = 10;
	localparam int ST_READS_SRC = 11;
	localparam int ST_READS_TWO = 12;
	localparam int ST_LANES_LSB = 16;
	localparam int ST_FLANE_LSB = 24;

	// Interlock cycle counts
	localparam int LOAD_USE_CYCLES = 1;
	localparam int MULT_CYCLES     = 4;

	// Major opcodes
	localparam logic [5:0] OP_SPECIAL = 6'h00;
	localparam logic [5:0] OP_REGIMM  = 6'h01;
	localparam logic [5:0] OP_JUMP    = 6'h02;
	localparam logic [5:0] OP_JLINK   = 6'h03;
	localparam logic [5:0] OP_COP0    = 6'h10;
	localparam logic [5:0] OP_SPEC2   = 6'h1c;

	// Function subcodes of the register layout
	localparam logic [5:0] FN_JREG      = 6'h08;
	localparam logic [5:0] FN_JREG_LINK = 6'h09;
	localparam logic [5:0] FN_MV_UPPER  = 6'h10;
	localparam logic [5:0] FN_MV_BOTTOM = 6'h12;

	typedef enum logic [1:0] {FMT_IMM, FMT_JUMP, FMT_REG} layout_e;
	typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_NONE} size_e;

	typedef struct packed {
		logic [5:0]  opcode;
		logic [4:0]  source_register_field;
		logic [4:0]  second_register_field;
		logic [4:0]  dest_register_field;
		logic [4:0]  shift_amount_field;
		logic [5:0]  function_subcode;
		logic [15:0] immediate_field;
		logic [25:0] jump_target_field;
	} fields_s;

endpackage

// >>> hw/flow_decode.sv
// Instruction format and control-flow decoder with AXI4-Lite register access
//
// Overview of operation
// - Each instruction is one 32-bit word taken at a word-aligned address, halfword-aligned in compressed mode.
// - Three layouts are recognised: immediate, jump and register.
// - The 16-bit immediate field is extracted from immediate layouts.
// - The 26-bit jump target field is extracted from jump layouts.
// - Register layouts yield destination, shift amount and function fields.
// - Load/store address is base plus sign-extended 16-bit offset only.
// - Reading a just-loaded register stalls with interlock cycles.
// - The effective address names the low-order byte for every size.
// - Big-endian puts low byte in top lane; little-endian in bottom.
// - Lanes come from size and three low address bits; bad ones fault.
// - Fetches are halfword in compressed mode, word otherwise, same lanes.
// - Moving a product register before the multiply ends stalls.
// - Every jump and branch has one delay slot, nullified after an untaken branch-likely.
// - Jump target is field shifted by 2 under the PC's upper 4 bits.
// - Register jumps take the full 32-bit address from the register.
// - Branch target is delay-slot address plus offset shifted, extended.
// - An untaken branch-likely nullifies its delay-slot instruction.
// - Immediate computations use immediate and register; register ones two.
// - Trap-initiating instructions decode only in the register layout.
// - A read-only flag reports whether interrupts end wait when disabled.
// - Without that capability a disabled interrupt does not end wait.
// - With it, any active interrupt line ends the wait state.
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module flow_decode
	import flow_decode_pkg::*;
#(
	parameter bit          WAKE_OVERRIDE = 1'b1,
	parameter int          IRQ_LINES     = 6,
	parameter int unsigned LOAD_STALL    = LOAD_USE_CYCLES,
	parameter int unsigned MULT_STALL    = MULT_CYCLES
) (
	// Clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// AXI4-Lite write address and data
	input  wire logic                 awvalid,
	output      logic                 awready,
	input  wire logic [7:0]           awaddr,
	input  wire logic [2:0]           awprot,
	input  wire logic                 wvalid,
	output      logic                 wready,
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	// AXI4-Lite write response
	output      logic                 bvalid,
	input  wire logic                 bready,
	output      logic [1:0]           bresp,
	// AXI4-Lite read
	input  wire logic                 arvalid,
	output      logic                 arready,
	input  wire logic [7:0]           araddr,
	input  wire logic [2:0]           arprot,
	output      logic                 rvalid,
	input  wire logic                 rready,
	output      logic [31:0]          rdata,
	output      logic [1:0]           rresp,
	// Interrupt lines and sleep indication
	input  wire logic [IRQ_LINES-1:0] irq_lines,
	output      logic                 sleeping
);

	// Lane mask of an access inside a doubleword, little-endian view, bit-reversed when big is set
	function automatic logic [7:0] lane_mask(input size_e sz,
		input logic [2:0] ofs, input logic big);
		logic [7:0] base;
		logic [7:0] le;
		base = (sz == SZ_BYTE) ? 8'h01 : (sz == SZ_HALF) ? 8'h03 :
			(sz == SZ_WORD) ? 8'h0f : 8'h00;
		le = base << ofs;
		return big ? 8'({<<{le}}) : le;
	endfunction

	// Alignment check for an access size
	function automatic logic misaligned(input size_e sz,
		input logic [2:0] ofs);
		return (sz == SZ_HALF && ofs[0]) ||
			(sz == SZ_WORD && ofs[1:0] != 2'b00);
	endfunction

	// Bus state
	logic        aw_full_reg, w_full_reg;
	logic [7:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic [31:0] rdata_next;
	logic        rd_hit;

	// Software-visible state
	logic [3:0]  ctrl_reg;
	logic [31:0] instr_reg, pc_reg, srca_reg, srcb_reg;
	logic        waiting_reg;

	// Pipeline state
	logic [7:0]  stall_cnt_reg;
	logic [7:0]  mult_cnt_reg;
	logic        load_pend_reg;
	logic [4:0]  load_dest_reg;
	logic        slot_reg, nullify_reg;
	logic        next_slot_reg, next_null_reg;
	logic        issue_d_reg, last_stall_reg;

	// Interrupt line synchroniser, three stages
	logic [IRQ_LINES-1:0] irq_s1_reg, irq_s2_reg, irq_s3_reg, irq_reg;

	wire logic do_write = aw_full_reg && w_full_reg && !bvalid;
	wire logic wr_hit   = (aw_addr_reg[7:2] <= WAIT_OFS[7:2]);
	wire logic issue    = do_write && aw_addr_reg == INSTR_OFS;
	wire logic big      = ctrl_reg[CTRL_BIG_BIT];

	// Field split
	fields_s f;
	assign f = fields_s'({instr_reg[31:26], instr_reg[25:21],
		instr_reg[20:16], instr_reg[15:11], instr_reg[10:6],
		instr_reg[5:0], instr_reg[15:0], instr_reg[25:0]});

	wire logic is_special = f.opcode == OP_SPECIAL;
	wire logic is_jfmt    = f.opcode == OP_JUMP || f.opcode == OP_JLINK;
	wire logic is_jreg    = is_special && (f.function_subcode == FN_JREG ||
		f.function_subcode == FN_JREG_LINK);
	wire logic is_regimm_br = f.opcode == OP_REGIMM &&
		(f.second_register_field[3:2] == 2'b00);
	wire logic is_branch  = f.opcode[5:2] == 4'b0001 ||
		f.opcode[5:2] == 4'b0101 || is_regimm_br;
	wire logic is_likely  = f.opcode[5:2] == 4'b0101 ||
		(is_regimm_br && f.second_register_field[1]);
	wire logic is_load    = f.opcode[5:3] == 3'b100;
	wire logic is_store   = f.opcode[5:3] == 3'b101;
	wire logic is_mem     = is_load || is_store;
	wire logic is_alu_imm = f.opcode[5:3] == 3'b001;
	wire logic is_mult    = (is_special && f.function_subcode[5:2] == 4'h6)
		|| (f.opcode == OP_SPEC2 && f.function_subcode[5:3] == 3'b000);
	wire logic is_mv_prod = is_special &&
		(f.function_subcode == FN_MV_UPPER ||
		 f.function_subcode == FN_MV_BOTTOM);
	wire logic is_trap    = is_special && (f.function_subcode == 6'h0c ||
		f.function_subcode == 6'h0d ||
		(f.function_subcode[5:3] == 3'b110 &&
		 f.function_subcode != 6'h35 &&
		 f.function_subcode != 6'h37));

	// Layout classification
	layout_e layout;
	assign layout = is_jfmt ? FMT_JUMP :
		(is_special || f.opcode == OP_SPEC2) ? FMT_REG : FMT_IMM;

	// Known register-layout subcodes
	wire logic spec_known = !(f.function_subcode inside {6'h01, 6'h05,
		6'h0e, 6'h14, 6'h15, 6'h16, 6'h17, 6'h1c, 6'h1d, 6'h1e, 6'h1f,
		6'h28, 6'h29, 6'h2c, 6'h2d, 6'h2e, 6'h2f, 6'h35, 6'h37,
		6'h38, 6'h39, 6'h3a, 6'h3b, 6'h3c, 6'h3d, 6'h3e, 6'h3f});
	wire logic spec2_known = f.function_subcode inside {6'h00, 6'h01,
		6'h02, 6'h04, 6'h05, 6'h20, 6'h21};
	wire logic op_known = is_jfmt || is_branch || is_alu_imm ||
		f.opcode == OP_COP0 ||
		f.opcode inside {6'h20, 6'h21, 6'h23, 6'h24, 6'h25,
			6'h28, 6'h29, 6'h2b} ||
		(is_special && spec_known) ||
		(f.opcode == OP_SPEC2 && spec2_known);
	wire logic reserved = !op_known;

	// Operand use: register forms, stores and equality branches read two registers, jumps none, other immediate forms one
	wire logic reads_second = layout == FMT_REG || is_store ||
		(is_branch && f.opcode[1] == 1'b0 && !is_regimm_br);
	wire logic reads_source = layout != FMT_JUMP;

	// Addresses and targets
	wire logic [31:0] imm_sext = {{16{f.immediate_field[15]}},
		f.immediate_field};
	wire logic [31:0] eff_addr = srca_reg + imm_sext;
	wire logic [31:0] slot_pc  = pc_reg + 32'h4;
	wire logic [31:0] br_tgt   = slot_pc + {imm_sext[29:0], 2'b00};
	wire logic [31:0] jmp_tgt  = {pc_reg[31:28], f.jump_target_field,
		2'b00};
	wire logic [31:0] target = is_jreg ? srca_reg :
		is_jfmt ? jmp_tgt : br_tgt;

	// Access size and lanes
	size_e mem_size;
	assign mem_size = !is_mem ? SZ_NONE :
		(f.opcode[1:0] == 2'b00) ? SZ_BYTE :
		(f.opcode[1:0] == 2'b01) ? SZ_HALF :
		(f.opcode[1:0] == 2'b11) ? SZ_WORD : SZ_NONE;
	wire logic addr_err = is_mem && (mem_size == SZ_NONE ||
		misaligned(mem_size, eff_addr[2:0]));
	wire logic [7:0] lanes = addr_err ? 8'h00 :
		lane_mask(mem_size, eff_addr[2:0], big);
	size_e fetch_size;
	assign fetch_size = ctrl_reg[CTRL_COMP_BIT] ? SZ_HALF : SZ_WORD;
	wire logic fetch_err = misaligned(fetch_size, pc_reg[2:0]);
	wire logic [7:0] fetch_lanes = lane_mask(fetch_size, pc_reg[2:0], big);

	// Branch condition on the two source values
	wire logic s_eq  = srca_reg == srcb_reg;
	wire logic s_neg = srca_reg[31];
	wire logic s_zero = srca_reg == 32'h0;
	logic taken;
	assign taken = is_jfmt || is_jreg ||
		(is_regimm_br ? (s_neg ^ f.second_register_field[0]) :
		 f.opcode[1:0] == 2'b00 ? s_eq :
		 f.opcode[1:0] == 2'b01 ? !s_eq :
		 f.opcode[1:0] == 2'b10 ? (s_neg || s_zero) :
		 !(s_neg || s_zero));

	// Interlock sources for the instruction now issuing
	wire logic [31:0] nw = w_data_reg;
	wire logic load_hit = load_pend_reg && load_dest_reg != 5'h0 &&
		(nw[25:21] == load_dest_reg || nw[20:16] == load_dest_reg);
	wire logic mv_next = nw[31:26] == OP_SPECIAL &&
		(nw[5:0] == FN_MV_UPPER || nw[5:0] == FN_MV_BOTTOM);
	wire logic [7:0] load_wait = load_hit ? 8'(LOAD_STALL) : 8'h0;
	wire logic [7:0] mult_wait = mv_next ? mult_cnt_reg : 8'h0;
	wire logic [7:0] stall_next = (mult_wait > load_wait) ?
		mult_wait : load_wait;
	wire logic stalled = stall_cnt_reg != 8'h0;
	wire logic effective = !nullify_reg;

	// Wake on synchronised interrupt lines
	wire logic irq_any  = |irq_reg;
	wire logic wake_ok  = WAKE_OVERRIDE || (ctrl_reg[CTRL_IE_BIT] &&
		!ctrl_reg[CTRL_EXEMPT_BIT]);
	wire logic wake     = waiting_reg && irq_any && wake_ok;

	// Status word and read selection
	wire logic [31:0] status = {fetch_lanes, lanes, 3'h0, reads_second,
		reads_source, waiting_reg, last_stall_reg, taken, nullify_reg,
		slot_reg, is_trap, reserved, fetch_err, addr_err, layout};
	assign rd_hit = araddr[7:2] <= CFG7_OFS[7:2];
	always_comb begin
		case (araddr)
			CTRL_OFS:   rdata_next = {28'h0, ctrl_reg};
			INSTR_OFS:  rdata_next = instr_reg;
			PC_OFS:     rdata_next = pc_reg;
			SRCA_OFS:   rdata_next = srca_reg;
			SRCB_OFS:   rdata_next = srcb_reg;
			WAIT_OFS:   rdata_next = {31'h0, waiting_reg};
			STATUS_OFS: rdata_next = status;
			EA_OFS:     rdata_next = eff_addr;
			TGT_OFS:    rdata_next = target;
			FIELD_OFS:  rdata_next = {16'h0, f.dest_register_field,
				f.shift_amount_field, f.function_subcode};
			IMM_OFS:    rdata_next = {16'h0, f.immediate_field};
			CFG7_OFS:   rdata_next = {31'h0, WAKE_OVERRIDE};
			default:    rdata_next = 32'h0;
		endcase
	end

	// Handshakes: a stalled pipeline holds off the next instruction
	assign awready = !aw_full_reg && !stalled;
	assign wready  = !w_full_reg && !stalled;
	assign arready = !rvalid;
	assign sleeping = waiting_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			aw_addr_reg <= 8'h0;
			w_data_reg  <= 32'h0;
			w_strb_reg  <= 4'h0;
			bvalid      <= 1'b0;
			bresp       <= 2'b00;
			rvalid      <= 1'b0;
			rdata       <= 32'h0;
			rresp       <= 2'b00;
		end else begin
			if (awvalid && awready) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= awaddr;
			end
			if (wvalid && wready) begin
				w_full_reg <= 1'b1;
				w_data_reg <= wdata;
				w_strb_reg <= wstrb;
			end
			if (do_write) begin
				aw_full_reg <= 1'b0;
				w_full_reg  <= 1'b0;
				bvalid      <= 1'b1;
				bresp       <= wr_hit ? 2'b00 : 2'b10;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rdata  <= rdata_next;
				rresp  <= rd_hit ? 2'b00 : 2'b10;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// Register writes; partial strobes are honoured per byte, except for the instruction and wait registers
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw_d, input logic [3:0] st);
		for (int i = 0; i < 4; i++)
			if (st[i])
				old[i*8 +: 8] = nw_d[i*8 +: 8];
		return old;
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg  <= CTRL_RESET;
			instr_reg <= 32'h0;
			pc_reg    <= 32'h0;
			srca_reg  <= 32'h0;
			srcb_reg  <= 32'h0;
		end else if (do_write) begin
			unique case (aw_addr_reg)
				CTRL_OFS:  ctrl_reg  <= 4'(merge({28'h0, ctrl_reg},
					w_data_reg, w_strb_reg));
				INSTR_OFS: instr_reg <= w_data_reg;
				PC_OFS:    pc_reg    <= merge(pc_reg, w_data_reg, w_strb_reg);
				SRCA_OFS:  srca_reg  <= merge(srca_reg, w_data_reg,
					w_strb_reg);
				SRCB_OFS:  srcb_reg  <= merge(srcb_reg, w_data_reg,
					w_strb_reg);
				default:   ;
			endcase
		end
	end

	// Issue sequencing: interlocks, delay slot and nullification
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stall_cnt_reg <= 8'h0;
			mult_cnt_reg  <= 8'h0;
			load_pend_reg <= 1'b0;
			load_dest_reg <= 5'h0;
			slot_reg      <= 1'b0;
			nullify_reg   <= 1'b0;
			next_slot_reg <= 1'b0;
			next_null_reg <= 1'b0;
			issue_d_reg   <= 1'b0;
			last_stall_reg <= 1'b0;
		end else if (issue) begin
			issue_d_reg   <= 1'b1;
			last_stall_reg <= stall_next != 8'h0;
			stall_cnt_reg <= stall_next;
			mult_cnt_reg  <= mult_cnt_reg - mult_wait;
			slot_reg      <= next_slot_reg;
			nullify_reg   <= next_null_reg;
			load_pend_reg <= 1'b0;
		end else begin
			if (stalled)
				stall_cnt_reg <= stall_cnt_reg - 8'h1;
			if (mult_cnt_reg != 8'h0)
				mult_cnt_reg <= mult_cnt_reg - 8'h1;
			// One cycle after issue the decoded word is stable
			issue_d_reg <= 1'b0;
			if (issue_d_reg) begin
				load_pend_reg <= is_load && effective;
				load_dest_reg <= f.second_register_field;
				if (is_mult && effective)
					mult_cnt_reg <= 8'(MULT_STALL);
				next_slot_reg <= (is_branch || is_jfmt || is_jreg) &&
					effective;
				next_null_reg <= is_likely && !taken && effective;
			end
		end
	end

	// Interrupt lines pass three stages; a change counts once two agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_s1_reg  <= {IRQ_LINES{1'b0}};
			irq_s2_reg  <= {IRQ_LINES{1'b0}};
			irq_s3_reg  <= {IRQ_LINES{1'b0}};
			irq_reg     <= {IRQ_LINES{1'b0}};
			waiting_reg <= 1'b0;
		end else begin
			irq_s1_reg <= irq_lines;
			irq_s2_reg <= irq_s1_reg;
			irq_s3_reg <= irq_s2_reg;
			irq_reg    <= (irq_s2_reg & irq_s3_reg) |
				(irq_reg & (irq_s2_reg | irq_s3_reg));
			if (do_write && aw_addr_reg == WAIT_OFS && w_data_reg[0])
				waiting_reg <= 1'b1;
			else if (wake)
				waiting_reg <= 1'b0;
		end
	end

	sequence load_use_issue;
		issue && load_hit;
	endsequence
	chk_load_stall: assert property (
		@(posedge aclk) disable iff (!aresetn) load_use_issue |=> stalled)
		else $error("Load use issued without a stall");
	chk_stall_holds: assert property (
		@(posedge aclk) disable iff (!aresetn)
		stalled |-> !awready && !wready)
		else $error("Instruction accepted during a stall");
	chk_product_stall: assert property (
		@(posedge aclk) disable iff (!aresetn)
		issue && mv_next && mult_cnt_reg != 8'h0 |=> stalled)
		else $error("Product move issued without a stall");
	chk_slot_marked: assert property (
		@(posedge aclk) disable iff (!aresetn)
		issue && next_slot_reg |=> slot_reg)
		else $error("Delay slot not marked");
	chk_likely_null: assert property (
		@(posedge aclk) disable iff (!aresetn)
		issue && next_null_reg |=> nullify_reg && !effective)
		else $error("Untaken likely slot not nullified");
	chk_bad_lanes: assert property (
		@(posedge aclk) disable iff (!aresetn)
		addr_err |-> lanes == 8'h00)
		else $error("Lanes selected on an address error");
	chk_irq_wake: assert property (
		@(posedge aclk) disable iff (!aresetn)
		waiting_reg && irq_any && WAKE_OVERRIDE && !do_write
		|=> !waiting_reg)
		else $error("Active line did not end the wait");

endmodule

// >>> testbench/flow_decode_tb_top.sv
// Self-checking bench for the instruction decoder over AXI4-Lite
`timescale 1ns/1ps
module flow_decode_tb_top;
	import flow_decode_pkg::*;

	localparam logic [31:0] BASE_PC = 32'hb000_1000;

	logic        aclk;
	logic        aresetn;
	logic        awvalid;
	logic        awready;
	logic [7:0]  awaddr;
	logic        wvalid;
	logic        wready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        bvalid;
	logic        bready;
	logic [1:0]  bresp;
	logic        arvalid;
	logic        arready;
	logic [7:0]  araddr;
	logic        rvalid;
	logic        rready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic [5:0]  irq_lines;
	logic        sleeping;
	int          failures;
	int          tests_run;
	logic [31:0] rd_val;
	logic [1:0]  rd_resp;
	logic [31:0] exp;

	flow_decode #(.WAKE_OVERRIDE(1'b1), .IRQ_LINES(6)) u_flow_decode (
		.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.awprot(3'h0), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.arprot(3'h0), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp),
		.irq_lines(irq_lines), .sleeping(sleeping)
	);

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen,
			input logic [31:0] expv);
		tests_run++;
		if (seen !== expv) begin
			failures++;
			$display("FAIL %s expected %h seen %h", name, expv, seen);
		end
	endtask

	// Hang guard: a wait that runs out of cycles ends the run
	task automatic timed_out(input string name);
		failures++;
		$display("FAIL %s expected answer seen timeout", name);
		end_of_test();
	endtask

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		bit aw_done;
		bit w_done;
		int n;
		aw_done = 0;
		w_done = 0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100 && !(aw_done && w_done); n++) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) begin
				aw_done = 1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready === 1'b1) begin
				w_done = 1;
				wvalid <= 1'b0;
			end
		end
		if (!(aw_done && w_done)) timed_out("write address or data");
		for (n = 0; n < 100 && bvalid !== 1'b1; n++) @(posedge aclk);
		if (bvalid !== 1'b1) timed_out("write response");
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [7:0] a);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100 && !(arvalid && arready === 1'b1); n++)
			@(posedge aclk);
		if (arready !== 1'b1) timed_out("read address");
		arvalid <= 1'b0;
		for (n = 0; n < 100 && rvalid !== 1'b1; n++) @(posedge aclk);
		if (rvalid !== 1'b1) timed_out("read data");
		rd_val = rdata;
		rd_resp = rresp;
		rready <= 1'b0;
	endtask

	// Presents one instruction with its pc and two source operands
	task automatic decode(input logic [31:0] pc, input logic [31:0] a,
			input logic [31:0] b, input logic [31:0] instr);
		axi_write(PC_OFS, pc);
		axi_write(SRCA_OFS, a);
		axi_write(SRCB_OFS, b);
		axi_write(INSTR_OFS, instr);
	endtask

	task automatic read_status();
		axi_read(STATUS_OFS);
	endtask

	// Harmless immediate add placed in every delay slot
	task automatic fill_slot();
		decode(BASE_PC + 32'h4, 32'h0, 32'h0, 32'h2400_0000);
	endtask

	initial begin
		int i;
		int n;
		failures = 0;
		tests_run = 0;
		aresetn = 1'b0;
		awvalid = 1'b0;
		awaddr = 8'h00;
		wvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'hf;
		bready = 1'b0;
		arvalid = 1'b0;
		araddr = 8'h00;
		rready = 1'b0;
		irq_lines = 6'h00;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(CTRL_OFS);
		check("ctrl reset", rd_val[3:0], {28'h0, CTRL_RESET});
		axi_read(CFG7_OFS);
		check("wake override flag", rd_val[0], 1'b1);
		axi_read(8'h80);
		check("unmapped resp", rd_resp[1], 1'b1);
		// Jump layout
		decode(BASE_PC, 32'h0, 32'h0, {OP_JUMP, 26'h2345678});
		axi_read(TGT_OFS);
		exp = {BASE_PC[31:28], 26'h2345678, 2'b00};
		check("jump target", rd_val, exp);
		read_status();
		check("jump layout", rd_val[1:0], FMT_JUMP);
		fill_slot();
		read_status();
		check("jump slot", rd_val[ST_SLOT], 1'b1);
		check("imm one reg", rd_val[ST_READS_TWO], 1'b0);
		// Register-indirect jump
		decode(BASE_PC, 32'h8765_4320, 32'h0,
			{OP_SPECIAL, 5'd4, 15'h0, FN_JREG});
		axi_read(TGT_OFS);
		check("jreg target", rd_val, 32'h8765_4320);
		read_status();
		check("reg layout", rd_val[1:0], FMT_REG);
		fill_slot();
		// Branch with negative offset, equal operands
		decode(BASE_PC, 32'h5, 32'h5, {6'h04, 5'd1, 5'd2, 16'hfffe});
		axi_read(TGT_OFS);
		exp = BASE_PC + 32'h4 + 32'hffff_fff8;
		check("branch target", rd_val, exp);
		axi_read(IMM_OFS);
		check("immediate", rd_val[15:0], 16'hfffe);
		fill_slot();
		// Branch-likely not taken then taken; the slot shows the outcome
		decode(BASE_PC, 32'h5, 32'h6, {6'h14, 5'd1, 5'd2, 16'h0010});
		fill_slot();
		read_status();
		check("likely untaken", rd_val[ST_NULLIFY], 1'b1);
		check("likely slot", rd_val[ST_SLOT], 1'b1);
		decode(BASE_PC, 32'h6, 32'h6, {6'h14, 5'd1, 5'd2, 16'h0010});
		fill_slot();
		read_status();
		check("likely taken", rd_val[ST_NULLIFY], 1'b0);
		// Load word effective address with negative displacement
		decode(BASE_PC, 32'h1000_0000, 32'h0, {6'h23, 5'd3, 5'd4, 16'h8004});
		axi_read(EA_OFS);
		check("load address", rd_val, 32'h0fff_8004);
		read_status();
		check("imm layout", rd_val[1:0], FMT_IMM);
		check("aligned word", rd_val[ST_ADDR_ERR], 1'b0);
		decode(BASE_PC, 32'h1000_0002, 32'h0, {6'h23, 5'd3, 5'd4, 16'h0});
		read_status();
		check("misaligned word", rd_val[ST_ADDR_ERR], 1'b1);
		// The load above wrote register 4; reading it next interlocks
		decode(BASE_PC, 32'h0, 32'h0, {6'h09, 5'd4, 5'd5, 16'h0});
		read_status();
		check("load use stall", rd_val[ST_STALL], 1'b1);
		decode(BASE_PC, 32'h0, 32'h0, {6'h09, 5'd1, 5'd2, 16'h0});
		read_status();
		check("no stall", rd_val[ST_STALL], 1'b0);
		// Product move right after a multiply interlocks
		decode(BASE_PC, 32'h3, 32'h5, {OP_SPECIAL, 5'd1, 5'd2, 10'h0, 6'h18});
		axi_write(INSTR_OFS, {OP_SPECIAL, 10'h0, 5'd3, 5'd0, FN_MV_UPPER});
		read_status();
		check("product stall", rd_val[ST_STALL], 1'b1);
		// Byte lanes for every offset, both byte orders
		for (i = 0; i < 16; i++) begin
			axi_write(CTRL_OFS, {31'h0, i[3]});
			decode(BASE_PC, {29'h0, i[2:0]}, 32'h0,
				{6'h20, 5'd3, 5'd4, 16'h0});
			read_status();
			exp = i[3] ? (32'h80 >> i[2:0]) : (32'h01 << i[2:0]);
			check("byte lanes", rd_val[ST_LANES_LSB+:8], exp[7:0]);
		end
		// Fetch alignment in word mode
		axi_write(CTRL_OFS, 32'h1);
		decode(BASE_PC + 32'h2, 32'h0, 32'h0, {OP_JUMP, 26'h0});
		read_status();
		check("word fetch align", rd_val[ST_FETCH_ERR], 1'b1);
		fill_slot();
		// Trap and reserved opcodes
		decode(BASE_PC, 32'h1, 32'h1,
			{OP_SPECIAL, 5'd1, 5'd2, 5'd6, 5'd9, 6'h34});
		read_status();
		check("trap decode", rd_val[ST_TRAP], 1'b1);
		check("reg two regs", rd_val[ST_READS_TWO], 1'b1);
		axi_read(FIELD_OFS);
		check("reg fields", rd_val, {16'h0, 5'd6, 5'd9, 6'h34});
		decode(BASE_PC, 32'h0, 32'h0, {6'h3b, 26'h0});
		read_status();
		check("reserved op", rd_val[ST_RESV], 1'b1);
		// Wait with interrupts disabled, woken by a raw line
		axi_write(WAIT_OFS, 32'h1);
		for (n = 0; n < 50 && sleeping !== 1'b1; n++) @(posedge aclk);
		check("enter wait", sleeping, 1'b1);
		irq_lines <= 6'h04;
		for (n = 0; n < 50 && sleeping !== 1'b0; n++) @(posedge aclk);
		check("wake on line", sleeping, 1'b0);
		irq_lines <= 6'h00;
		end_of_test();
	end

	initial begin
		repeat (50000) @(posedge aclk);
		timed_out("overall run");
	end
endmodule
